// ===== logic/prs_sequencer.sv
// Reset and power-up initialization sequencer of the pseudo-static memory.
// Function
// - Finish self-initialization within 150 microseconds.
// - Init count starts only after reset release.
// - Refresh during init, then accept transactions.
// - Reset low returns device to the reset state.
// - Reset loads configuration register defaults.
// - Reset halts self-refresh, array invalid.
// - Reset exits hybrid and deep sleep.
// - Refresh resumes after reset, counter defaulted.
// - Reset low is the sleep exit path.
`timescale 1ns/1ps
module prs_sequencer #(
   parameter int INIT_CYCLES = prs_pkg::INIT_WAIT_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        mem_reset_n,
   input  wire logic        select_n,
   input  wire logic        sleep_req,
   input  wire logic        deep_req,
   output logic             ready,
   output logic             refresh_en,
   output logic             refresh_tick,
   output logic [12:0]      refresh_row,
   output logic             array_valid,
   output logic [15:0]      cfg0,
   output logic [15:0]      cfg1,
   output logic             bus_oe_n,
   output logic [2:0]       power_state
);
   // ------------------------------------------------------------------
   // Reset release and state record
   // ------------------------------------------------------------------
   typedef struct packed {
      prs_pkg::prs_state_t st;
      logic [prs_pkg::CNT_W-1:0] cnt;
      logic [12:0]  row;
      logic         valid;
      logic         tick;
      logic [15:0]  cfg0;
      logic [15:0]  cfg1;
   } prs_regs_t;

   logic      rst_meta_q;
   logic      rst_sync_q;
   logic      hw_reset;
   prs_regs_t r_q;
   prs_regs_t r_d;

   // Releases the system reset through two flip-flops.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // The memory reset pin acts as the hardware reset while it is low.
   assign hw_reset = !mem_reset_n;

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   // Computes the next value of every state element.
   always_comb begin
      r_d      = r_q;
      r_d.tick = 1'b0;
      if (hw_reset) begin
         r_d.st    = prs_pkg::PRS_RESET;
         r_d.cfg0  = prs_pkg::CFG0_DEFAULT;
         r_d.cfg1  = prs_pkg::CFG1_DEFAULT;
         r_d.row   = prs_pkg::ROW_DEFAULT;
         r_d.valid = 1'b0;
         r_d.cnt   = '0;
      end else begin
         case (r_q.st)
            prs_pkg::PRS_RESET: begin
               r_d.st = prs_pkg::PRS_INIT;
            end
            prs_pkg::PRS_INIT: begin
               r_d.tick = 1'b1;
               r_d.row  = r_q.row + 13'h0001;
               if (r_q.cnt == prs_pkg::CNT_W'(INIT_CYCLES - 1)) begin
                  r_d.st    = prs_pkg::PRS_STANDBY;
                  r_d.valid = 1'b1;
               end else begin
                  r_d.cnt = r_q.cnt + prs_pkg::CNT_W'(1);
               end
            end
            prs_pkg::PRS_STANDBY: begin
               if (!select_n) begin
                  r_d.st = prs_pkg::PRS_ACTIVE;
               end else if (deep_req) begin
                  r_d.st = prs_pkg::PRS_DEEPEST_SLEEP;
               end else if (sleep_req) begin
                  r_d.st = prs_pkg::PRS_RETAINED_SLEEP;
               end
            end
            prs_pkg::PRS_ACTIVE: begin
               if (select_n) begin
                  r_d.st = prs_pkg::PRS_STANDBY;
               end
            end
            prs_pkg::PRS_DEEPEST_SLEEP: begin
               r_d.valid = 1'b0;   // Deepest sleep keeps no data.
            end
            default: begin
               r_d.st = r_q.st;    // Left only by reset.
            end
         endcase
      end
   end

   // Registers the state record.
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         r_q.st    <= prs_pkg::PRS_RESET;
         r_q.cnt   <= '0;
         r_q.row   <= prs_pkg::ROW_DEFAULT;
         r_q.valid <= 1'b0;
         r_q.tick  <= 1'b0;
         r_q.cfg0  <= prs_pkg::CFG0_DEFAULT;
         r_q.cfg1  <= prs_pkg::CFG1_DEFAULT;
      end else begin
         r_q <= r_d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Ready and refresh follow state; pins float unless active.
   assign ready        = (r_q.st == prs_pkg::PRS_STANDBY) || (r_q.st == prs_pkg::PRS_ACTIVE);
   assign refresh_en   = (r_q.st != prs_pkg::PRS_RESET)
                       && (r_q.st != prs_pkg::PRS_DEEPEST_SLEEP);
   assign refresh_tick = r_q.tick;
   assign refresh_row  = r_q.row;
   assign array_valid  = r_q.valid;
   assign cfg0         = r_q.cfg0;
   assign cfg1         = r_q.cfg1;
   assign bus_oe_n     = !(r_q.st == prs_pkg::PRS_ACTIVE);
   assign power_state  = r_q.st;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   property p_init_len;
      @(posedge clock) disable iff (!rst_sync_q || hw_reset)
      (r_q.st == prs_pkg::PRS_RESET && !hw_reset) |=> (r_q.st == prs_pkg::PRS_INIT)
         [*8];
   endproperty
   a_init_len: assert property (p_init_len) else $error("Init ended too early.");

   // The last init count must hand over to a ready device with a valid array.
   property p_init_done;
      @(posedge clock) disable iff (!rst_sync_q)
      (r_q.st == prs_pkg::PRS_INIT && !hw_reset
       && r_q.cnt == prs_pkg::CNT_W'(INIT_CYCLES - 1))
         |=> (ready && array_valid && refresh_en);
   endproperty
   a_init_done: assert property (p_init_done) else $error("Init did not end on time.");

   property p_reset_state;
      @(posedge clock) disable iff (!rst_sync_q)
      hw_reset |=> (r_q.st == prs_pkg::PRS_RESET && !ready);
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("Reset did not stop.");

   property p_no_count;
      @(posedge clock) disable iff (!rst_sync_q)
      hw_reset |=> (r_q.cnt == '0);
   endproperty
   a_no_count: assert property (p_no_count) else $error("Init counted in reset.");

   property p_cfg_def;
      @(posedge clock) disable iff (!rst_sync_q)
      hw_reset |=> (cfg0 == prs_pkg::CFG0_DEFAULT && cfg1 == prs_pkg::CFG1_DEFAULT);
   endproperty
   a_cfg_def: assert property (p_cfg_def) else $error("Config not defaulted.");

   property p_refresh_halt;
      @(posedge clock) disable iff (!rst_sync_q)
      hw_reset |=> (!refresh_en && !array_valid);
   endproperty
   a_refresh_halt: assert property (p_refresh_halt) else $error("Refresh ran in reset.");

   property p_sleep_exit;
      @(posedge clock) disable iff (!rst_sync_q)
      (hw_reset && (r_q.st == prs_pkg::PRS_DEEPEST_SLEEP
                    || r_q.st == prs_pkg::PRS_RETAINED_SLEEP)) |=> (r_q.st == prs_pkg::PRS_RESET);
   endproperty
   a_sleep_exit: assert property (p_sleep_exit) else $error("Sleep not exited.");

   property p_row_resume;
      @(posedge clock) disable iff (!rst_sync_q)
      ($fell(hw_reset) && r_q.st == prs_pkg::PRS_RESET)
         |=> ##1 (refresh_tick && refresh_row == prs_pkg::ROW_DEFAULT + 13'h0001);
   endproperty
   a_row_resume: assert property (p_row_resume) else $error("Refresh did not resume.");

   property p_float;
      @(posedge clock) disable iff (!rst_sync_q)
      (!ready) |-> bus_oe_n;
   endproperty
   a_float: assert property (p_float) else $error("Pins driven before ready.");

   c_init_done: cover property (@(posedge clock) $rose(ready));
   c_reset_in_sleep: cover property (@(posedge clock)
      r_q.st == prs_pkg::PRS_DEEPEST_SLEEP ##1 hw_reset);
   c_active: cover property (@(posedge clock) r_q.st == prs_pkg::PRS_ACTIVE);
   c_retained: cover property (@(posedge clock) r_q.st == prs_pkg::PRS_RETAINED_SLEEP);
endmodule

// ===== logic/prs_pkg.sv
// Package of constants and types for the pseudo-static memory reset and init sequencer.
package prs_pkg;
   // ------------------------------------------------------------------
   // Timing constants
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_PS         = 25000;
   localparam int INIT_WAIT_TIME_US     = 150;
   localparam int RESET_PULSE_MIN_NS    = 200;
   localparam int RESET_HIGH_TO_SEL_NS  = 200;
   localparam int RESET_LOW_TO_SEL_NS   = 400;
   localparam int SUPPLY_LOW_HOLD_US    = 50;
   // Longest init time in whole cycles, one cycle kept back for the reset-release edge.
   localparam int INIT_WAIT_CYCLES      = (INIT_WAIT_TIME_US * 1000000) / CLK_PERIOD_PS - 1;
   localparam int CNT_W                 = 13;

   // ------------------------------------------------------------------
   // Configuration register defaults and array
   // ------------------------------------------------------------------
   localparam logic [15:0] CFG0_DEFAULT = 16'h8F1F;
   localparam logic [15:0] CFG1_DEFAULT = 16'h0002;
   localparam int          ROW_W        = 13;
   localparam logic [12:0] ROW_DEFAULT  = 13'h0000;
   localparam logic [12:0] ROW_LAST     = 13'h1FFF;

   // Power and sequencing states.
   typedef enum logic [2:0] {
      PRS_RESET,
      PRS_INIT,
      PRS_STANDBY,
      PRS_ACTIVE,
      PRS_RETAINED_SLEEP,
      PRS_DEEPEST_SLEEP
   } prs_state_t;
endpackage

// ===== verification/prs_host.sv
// Host model that drives the memory reset and chip select pins.
`timescale 1ns/1ps
module prs_host (
   input  wire logic clock,
   input  wire logic ready,
   output logic      mem_reset_n,
   output logic      select_n
);
   // Reset starts held low, and the host stays deselected during power-up.
   initial begin
      mem_reset_n = 1'b0;
      select_n    = 1'b1;
   end
   // Pulses reset low for n cycles; callers pass at least 8 (200 ns).
   task automatic pulse_reset(input int n);
      mem_reset_n = 1'b0;
      repeat (n) @(negedge clock);
      mem_reset_n = 1'b1;
   endtask
   // Selects for n cycles; a polite select first waits for ready and 8 more cycles.
   task automatic do_select(input int n, input bit polite);
      while (polite && ready !== 1'b1) @(negedge clock);
      if (polite) repeat (8) @(negedge clock);
      select_n = 1'b0;
      repeat (n) @(negedge clock);
      select_n = 1'b1;
   endtask
endmodule

// ===== verification/psram_reset_init_sequencer_tb_top.sv
// Testbench of the memory reset and init sequencer.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
   $display("ERROR %0t got %0h exp %0h", $time, a, e); end end
module psram_reset_init_sequencer_tb_top;
   typedef struct {logic sl; logic dp; logic [2:0] st;} prs_row_t;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        sleep_req = 1'b0;
   logic        deep_req = 1'b0;
   logic        ready, refresh_en, refresh_tick, array_valid, bus_oe_n;
   logic        mem_reset_n, select_n;
   logic [12:0] refresh_row;
   logic [15:0] cfg0, cfg1;
   logic [2:0]  power_state;
   int          checks = 0;
   int          fail_count = 0;
   int          ticks = 0;
   localparam int INIT_CYC = 10;
   prs_row_t    rows [4] = '{'{1'b0, 1'b0, 3'h2}, '{1'b1, 1'b0, 3'h4},
                             '{1'b0, 1'b1, 3'h5}, '{1'b1, 1'b1, 3'h5}};
   // Clock of 25 ns period.
   initial forever #12.5 clock = ~clock;
   // Counts refresh pulses of the init period.
   always @(posedge clock) if (refresh_tick === 1'b1) ticks++;
   prs_sequencer #(.INIT_CYCLES(INIT_CYC)) dut (.clock(clock), .reset_n(reset_n),
      .mem_reset_n(mem_reset_n), .select_n(select_n), .sleep_req(sleep_req),
      .deep_req(deep_req), .ready(ready), .refresh_en(refresh_en),
      .refresh_tick(refresh_tick), .refresh_row(refresh_row),
      .array_valid(array_valid), .cfg0(cfg0), .cfg1(cfg1), .bus_oe_n(bus_oe_n),
      .power_state(power_state));
   prs_host host (.clock(clock), .ready(ready), .mem_reset_n(mem_reset_n),
      .select_n(select_n));
   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Pulses memory reset, checks the reset state, then times the init.
   task automatic rst_init();
      fork
         host.pulse_reset(8);
         begin
            repeat (4) @(negedge clock);
            `CHK(power_state, 3'h0)
            `CHK({cfg0, cfg1}, {prs_pkg::CFG0_DEFAULT, prs_pkg::CFG1_DEFAULT})
            `CHK({refresh_en, array_valid, refresh_row}, {2'b00, prs_pkg::ROW_DEFAULT})
            `CHK(bus_oe_n, 1'b1)
         end
      join
      ticks = 0;
      repeat (INIT_CYC) @(posedge clock);
      #1 `CHK(ready, 1'b0)
      @(posedge clock);
      #1 `CHK({ready, array_valid, refresh_en}, 3'h7)
      `CHK(refresh_row, 13'(INIT_CYC))
      @(negedge clock);
      @(negedge clock);
      `CHK(ticks, INIT_CYC)
   endtask
   // Main sequence: power-up, table rows, then the awkward cases.
   initial begin
      repeat (8) @(negedge clock);
      reset_n = 1'b1;
      repeat (30) @(negedge clock);
      `CHK({ready, bus_oe_n}, 2'b01)
      `CHK(power_state, 3'h0)
      $display("test powerup_held done");
      foreach (rows[i]) begin
         rst_init();
         sleep_req = rows[i].sl;
         deep_req = rows[i].dp;
         repeat (3) @(negedge clock);
         `CHK(power_state, rows[i].st)
         sleep_req = 1'b0;
         deep_req = 1'b0;
         $display("test row %0d done", i);
      end
      host.pulse_reset(8);
      fork
         host.do_select(4, 1'b0);
         begin
            repeat (2) @(negedge clock);
            `CHK({ready, bus_oe_n}, 2'b01)
         end
      join
      repeat (12) @(negedge clock);
      `CHK(power_state, 3'h2)
      $display("test early_select done");
      fork
         host.do_select(6, 1'b1);
         begin
            repeat (11) @(negedge clock);
            `CHK({power_state, bus_oe_n}, 4'h6)
         end
      join
      repeat (3) @(negedge clock);
      `CHK(bus_oe_n, 1'b1)
      $display("test select done");
      give_verdict();
   end
   // Cuts a hang short; the tests need about 170 cycles.
   initial begin
      #50000;
      fail_count++;
      give_verdict();
   end
endmodule
